//--- qrtb_params.svh
// Constants for the quad retimer with bypass
`ifndef QRTB_PARAMS_SVH
`define QRTB_PARAMS_SVH
`define QRTB_NUM_CH 4
`define QRTB_CH_RST 4'h0
`define QRTB_STB_RST 1'b0
`define QRTB_SEL_ASYNC 1'b1
`define QRTB_SEL_SYNC 1'b0
`endif

//--- qrtb_pkg.sv
// Types for the quad retimer with bypass
`include "qrtb_params.svh"
package qrtb_pkg;
	typedef logic [`QRTB_NUM_CH-1:0] qrtb_lanes_t;
	typedef struct packed {
		logic mode_async;
		logic out_en;
	} qrtb_ctrl_t;
	typedef enum logic [0:0] {
		QRTB_MODE_SYNC = 1'b0,
		QRTB_MODE_ASYNC = 1'b1
	} qrtb_mode_t;
endpackage

//--- qrtb_core.sv
// Quad channel retimer with bypass and output gate
// Summary of operation
// RULE1: Sync mode: strobe rise moves sources to outputs
// RULE2: All four channels capture on same edge
// RULE3: Async mode: outputs follow sources one clock later, bypassing lane flops
// RULE4: Async mode ignores the capture strobe
// RULE5: Driver holds strobe steady in async mode
// RULE6: Gate high enables outputs per mode
// RULE7: Gate low forces all outputs low
// RULE8: Gate low ignores strobe, mode, sources
// RULE9: Outputs never invert source polarity
// RULE10: Channel flops reset to zero before first capture
`timescale 1ns/1ps
`include "qrtb_params.svh"
module qrtb_core
	import qrtb_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire qrtb_lanes_t I_CH_SRC,
	input wire logic I_CAP_STROBE,
	input wire qrtb_ctrl_t I_CTRL,
	output qrtb_lanes_t O_CH_DRV,
	output logic O_CAP_EVENT
);
	logic strobe_ff;
	logic cap_ok;
	qrtb_mode_t mode;
	qrtb_lanes_t lanes_ff;
	qrtb_lanes_t sel_data;
	qrtb_lanes_t nxt_drv;
	logic [`QRTB_NUM_CH-1:0] nxt_lanes;

	assign mode = qrtb_mode_t'(I_CTRL.mode_async);

	// Strobe history for rising-edge detection
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			strobe_ff <= `QRTB_STB_RST;
		end else begin
			strobe_ff <= I_CAP_STROBE;
		end
	end

	// Capture only in sync mode with gate open
	assign cap_ok = I_CAP_STROBE && !strobe_ff && I_CTRL.out_en &&
		(mode == QRTB_MODE_SYNC); // see RULE1 see RULE4 see RULE8
	assign O_CAP_EVENT = cap_ok;

	// Next lane value per channel, shared capture enable
	genvar g;
	generate
		for (g = 0; g < `QRTB_NUM_CH; g++) begin : g_lane
			assign nxt_lanes[g] = cap_ok ? I_CH_SRC[g] : lanes_ff[g]; // see RULE2
		end
	endgenerate

	// Lane flops, all channels load on one edge
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			lanes_ff <= `QRTB_CH_RST; // see RULE10
		end else begin
			lanes_ff <= nxt_lanes; // see RULE2
		end
	end

	// Mode mux and output gate, no inversion
	always_comb begin
		case (mode)
			QRTB_MODE_ASYNC: sel_data = I_CH_SRC; // see RULE3 see RULE9
			QRTB_MODE_SYNC: sel_data = lanes_ff; // see RULE1
			default: sel_data = lanes_ff;
		endcase
		nxt_drv = I_CTRL.out_en ? sel_data : `QRTB_CH_RST; // see RULE6 see RULE7
	end

	// Output register
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_CH_DRV <= `QRTB_CH_RST;
		end else begin
			O_CH_DRV <= nxt_drv;
		end
	end

	// Named steps of the transfer
	sequence s_sync_rise;
		I_CTRL.out_en && !I_CTRL.mode_async && I_CAP_STROBE && !strobe_ff;
	endsequence

	sequence s_sync_on;
		I_CTRL.out_en && !I_CTRL.mode_async;
	endsequence

	sequence s_async_on;
		I_CTRL.out_en && I_CTRL.mode_async;
	endsequence

	sequence s_gate_off;
		!I_CTRL.out_en;
	endsequence

	// Capture reaches the outputs one edge after the lanes load
	chk_sync_capture: assert property (@(posedge I_CORE_CLK) // see RULE1
		disable iff (!I_RST_N)
		s_sync_rise ##1 s_sync_on
		|=> O_CH_DRV == $past(I_CH_SRC, 2))
		else $error("sync capture did not reach outputs");

	chk_cap_event: assert property (@(posedge I_CORE_CLK) // see RULE1
		disable iff (!I_RST_N)
		s_sync_rise |-> O_CAP_EVENT)
		else $error("capture event missing on strobe rise");

	chk_lanes_idle: assert property (@(posedge I_CORE_CLK) // see RULE1
		disable iff (!I_RST_N)
		!O_CAP_EVENT |=> $stable(lanes_ff))
		else $error("lane flops moved without capture");

	chk_lanes_together: assert property (@(posedge I_CORE_CLK) // see RULE2
		disable iff (!I_RST_N)
		s_sync_rise |=> lanes_ff == $past(I_CH_SRC))
		else $error("channels did not capture together");

	chk_async_follow: assert property (@(posedge I_CORE_CLK) // see RULE3
		disable iff (!I_RST_N)
		s_async_on |=> O_CH_DRV == $past(I_CH_SRC))
		else $error("async output did not follow source");

	chk_cap_sync_only: assert property (@(posedge I_CORE_CLK) // see RULE4
		disable iff (!I_RST_N)
		O_CAP_EVENT |-> !I_CTRL.mode_async)
		else $error("capture event in async mode");

	chk_async_nostrobe: assert property (@(posedge I_CORE_CLK) // see RULE4
		disable iff (!I_RST_N)
		I_CTRL.mode_async |=> $stable(lanes_ff))
		else $error("strobe acted in async mode");

	chk_gate_low: assert property (@(posedge I_CORE_CLK) // see RULE7
		disable iff (!I_RST_N)
		!I_CTRL.out_en |=> O_CH_DRV == `QRTB_CH_RST)
		else $error("outputs not forced low");

	chk_gate_hold: assert property (@(posedge I_CORE_CLK) // see RULE8
		disable iff (!I_RST_N)
		!I_CTRL.out_en |-> !O_CAP_EVENT ##1 $stable(lanes_ff))
		else $error("gate low did not freeze capture");

	chk_sync_hold: assert property (@(posedge I_CORE_CLK) // see RULE6
		disable iff (!I_RST_N)
		(I_CTRL.out_en && !I_CTRL.mode_async) |=> O_CH_DRV == $past(lanes_ff))
		else $error("sync output not from lane flops");

	chk_gate_event: assert property (@(posedge I_CORE_CLK) // see RULE8
		disable iff (!I_RST_N)
		O_CAP_EVENT |-> I_CTRL.out_en)
		else $error("capture event while gate low");

	// Per channel polarity and gating
	generate
		for (g = 0; g < `QRTB_NUM_CH; g++) begin : g_lane_chk
			chk_no_invert: assert property (@(posedge I_CORE_CLK) // see RULE9
				disable iff (!I_RST_N)
				s_async_on |=> O_CH_DRV[g] == $past(I_CH_SRC[g]))
				else $error("async output polarity mismatch");

			chk_sync_polar: assert property (@(posedge I_CORE_CLK) // see RULE9
				disable iff (!I_RST_N)
				s_sync_rise ##1 s_sync_on
				|=> O_CH_DRV[g] == $past(I_CH_SRC[g], 2))
				else $error("sync output polarity mismatch");

			chk_lane_low: assert property (@(posedge I_CORE_CLK) // see RULE7
				disable iff (!I_RST_N)
				s_gate_off |=> !O_CH_DRV[g])
				else $error("channel output not forced low");

			chk_lane_hold: assert property (@(posedge I_CORE_CLK) // see RULE8
				disable iff (!I_RST_N)
				s_gate_off |=> lanes_ff[g] == $past(lanes_ff[g]))
				else $error("channel flop moved while gate low");

			chk_lane_sync: assert property (@(posedge I_CORE_CLK) // see RULE6
				disable iff (!I_RST_N)
				s_sync_on |=> O_CH_DRV[g] == $past(lanes_ff[g]))
				else $error("channel output not from its flop");
		end
	endgenerate

	// Gate reopening shows the held lanes in sync mode
	chk_gate_reopen: assert property (@(posedge I_CORE_CLK) // see RULE6
		disable iff (!I_RST_N)
		s_gate_off ##1 s_sync_on |=> O_CH_DRV == $past(lanes_ff))
		else $error("reopened gate did not show held lanes");

	// Gate reopening shows the live sources in async mode
	chk_gate_async: assert property (@(posedge I_CORE_CLK) // see RULE6
		disable iff (!I_RST_N)
		s_gate_off ##1 s_async_on |=> O_CH_DRV == $past(I_CH_SRC))
		else $error("reopened gate did not show sources");

	// Async mode never loads the lane flops
	chk_async_event: assert property (@(posedge I_CORE_CLK) // see RULE4
		disable iff (!I_RST_N)
		s_async_on |-> !O_CAP_EVENT)
		else $error("strobe captured in async mode");

	// A held strobe does not capture again
	chk_no_recapture: assert property (@(posedge I_CORE_CLK) // see RULE1
		disable iff (!I_RST_N)
		O_CAP_EVENT |=> !O_CAP_EVENT)
		else $error("strobe captured twice without falling");

	// Sync lanes only change on a capture edge
	chk_sync_stable: assert property (@(posedge I_CORE_CLK) // see RULE2
		disable iff (!I_RST_N)
		s_sync_on ##0 !O_CAP_EVENT |=> lanes_ff == $past(lanes_ff))
		else $error("lanes changed without strobe rise");
endmodule // qrtb_core

//--- qrtb_src_model.sv
// Upstream driver model for the quad retimer
`timescale 1ns/1ps
module qrtb_src_model
	import qrtb_pkg::*;
(
	input wire logic i_clk,
	input wire qrtb_lanes_t i_src,
	input wire logic i_stb,
	input wire qrtb_ctrl_t i_ctrl,
	input wire logic i_noisy,
	output qrtb_lanes_t o_src,
	output logic o_stb,
	output qrtb_ctrl_t o_ctrl
);
	always @(posedge i_clk) begin
		o_src <= i_src;
		o_ctrl <= i_ctrl;
		// Strobe held steady in async mode unless told to misbehave
		if (!i_ctrl.mode_async || i_noisy) o_stb <= i_stb;
	end
endmodule // qrtb_src_model

//--- test_qrtb_core.sv
// Testbench for the quad retimer
`timescale 1ns/1ps
module test_qrtb_core
	import qrtb_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, stb = 1'b0, noisy = 1'b0, m_stb;
	logic cap_ev;
	logic [7:0] n_cap = 8'h00;
	qrtb_lanes_t src = '0, drv, m_src;
	qrtb_ctrl_t ctrl = '0, m_ctrl;
	int mismatches = 0, n_compared = 0, cyc = 0;
	qrtb_src_model i_qrtb_src_model (.i_clk(clk), .i_src(src), .i_stb(stb),
		.i_ctrl(ctrl), .i_noisy(noisy), .o_src(m_src), .o_stb(m_stb),
		.o_ctrl(m_ctrl));
	qrtb_core i_qrtb_core (.I_CORE_CLK(clk), .I_RST_N(rst_n),
		.I_CH_SRC(m_src), .I_CAP_STROBE(m_stb), .I_CTRL(m_ctrl),
		.O_CH_DRV(drv), .O_CAP_EVENT(cap_ev));
	always @(posedge clk) if (cap_ev === 1'b1) n_cap <= n_cap + 8'h01;
	task automatic chk_cap(input logic [7:0] exp);
		n_compared++;
		if (n_cap !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got %h exp %h", $time, n_cap, exp);
		end
	endtask
	initial forever #5 clk = ~clk;
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic chk(input qrtb_lanes_t exp);
		repeat (4) @(posedge clk);
		#1;
		n_compared++;
		if (drv !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got %h exp %h", $time, drv, exp);
		end
		@(posedge clk);
	endtask
	task automatic t_sync();
		ctrl <= 2'b01;
		src <= 4'ha;
		repeat (3) @(posedge clk);
		stb <= 1'b1;
		chk(4'ha);
		src <= 4'h5;
		stb <= 1'b0;
		chk(4'ha);
		stb <= 1'b1;
		chk(4'h5);
		chk_cap(8'h02);
	endtask
	task automatic t_async();
		ctrl <= 2'b11;
		noisy <= 1'b1;
		src <= 4'hc;
		stb <= 1'b0;
		chk(4'hc);
		stb <= 1'b1;
		chk(4'hc);
		ctrl <= 2'b01;
		chk(4'h5);
		chk_cap(8'h02);
	endtask
	task automatic t_gate();
		ctrl <= 2'b00;
		chk(4'h0);
		src <= 4'h6;
		stb <= 1'b0;
		ctrl <= 2'b10;
		chk(4'h0);
		stb <= 1'b1;
		chk(4'h0);
		ctrl <= 2'b01;
		chk(4'h5);
		chk_cap(8'h02);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_sync();
		t_async();
		t_gate();
		print_verdict();
	end
endmodule // test_qrtb_core
